// file: src/pef_pkg.sv
// constants and types shared by the event filter engine
// Overview of operation
// - thirty writable filter entries, one fixed alert policy entry.
// - each event is compared with every entry, matched actions merged.
// - merged actions run in priority order, resolving combinations.
// - power-down, soft, cycle and reset defer in 100 ms units, capped.
// - power-cycle ranks 3 and reset 4, both deferrable.
// - a matched power-down suppresses soft, cycle, reset and diag.
// - message event ranks 8 and ID LED 10, neither deferrable.
// - alert, sensor feedback, message and LED actions issue at once.
// - fault LED blinks until every requesting event has de-asserted.
// - a pending action whose delay shrinks takes precedence.
// - when enabled, each executed action is reported as a log entry.
// - soft-shutdown pulses the ACPI power button signal.
// - feedback starts a peripheral bus transfer or sets feedback pins.
// - the alert action has exactly one destination.
// - 200 ms NMI pulse on diag, not repeated until reset or power-down.
`default_nettype none
package pef_pkg;
  localparam int ENTRIES = 30;
  localparam int NACT = 10;
  localparam int DLY_W = 8;
  localparam int EVT_W = 16;
  // action bit positions, index order equals priority order
  localparam int ACT_PDOWN = 0;
  localparam int ACT_SOFT = 1;
  localparam int ACT_CYCLE = 2;
  localparam int ACT_RESET = 3;
  localparam int ACT_DIAG = 4;
  localparam int ACT_ALERT = 5;
  localparam int ACT_SENSFB = 6;
  localparam int ACT_MSG = 7;
  localparam int ACT_FLED = 8;
  localparam int ACT_IDLED = 9;
  // priority figures as numbered for the platform
  localparam int PRI_PDOWN = 1;
  localparam int PRI_SOFT = 2;
  localparam int PRI_CYCLE = 3;
  localparam int PRI_RESET = 4;
  localparam int PRI_MSG = 8;
  localparam int PRI_IDLED = 10;
  localparam logic [NACT-1:0] DEFERRABLE = 10'h00F;
  localparam logic [NACT-1:0] PDOWN_SUPPRESS = 10'h01E;
  localparam int CLK_MHZ = 125;
  localparam int UNIT_MS = 100;
  localparam int UNIT_CYC = UNIT_MS * 1000 * CLK_MHZ;
  localparam int NMI_MS = 200;
  localparam int NMI_CYC = NMI_MS * 1000 * CLK_MHZ;
  localparam int BTN_CYC_DEF = 16;
  localparam logic [DLY_W-1:0] MAX_DELAY = 8'hFF;
  localparam logic [EVT_W-1:0] ALERT_DEST = 16'h0001;
  typedef enum logic [1:0] {PEF_IDLE, PEF_SCAN, PEF_DONE} pef_state_t;
endpackage : pef_pkg
`default_nettype wire

// file: src/pef_timer.sv
// down counter used for the NMI and power button pulse widths
`default_nettype none
module pef_timer #(
  parameter int W = 32
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic load,
  input wire logic [W-1:0] value,
  output logic busy,
  output logic expire
);
  logic [W-1:0] cnt;
  logic [W-1:0] next_cnt;
  logic next_expire;

  always_comb begin
    next_cnt = cnt;
    next_expire = 1'b0;
    if (load) begin
      next_cnt = value;
    end else if (cnt != '0) begin
      next_cnt = cnt - 1'b1;
      next_expire = (cnt == {{(W-1){1'b0}}, 1'b1});
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt <= '0;
      expire <= 1'b0;
    end else begin
      cnt <= next_cnt;
      expire <= next_expire;
    end
  end

  assign busy = (cnt != '0);
endmodule : pef_timer
`default_nettype wire

// file: src/pef_engine.sv
// platform event filter: match, merge, defer and dispatch actions
`default_nettype none
module pef_engine #(
  parameter int UNIT_CYCLES = pef_pkg::UNIT_CYC,
  parameter int NMI_CYCLES = pef_pkg::NMI_CYC,
  parameter int BTN_CYCLES = pef_pkg::BTN_CYC_DEF
) (
  input wire logic MCLK,
  input wire logic SYS_RST,
  input wire logic EVT_VALID,
  input wire logic EVT_EXTERNAL,
  input wire logic [pef_pkg::EVT_W-1:0] EVT_DATA,
  input wire logic EVT_ASSERT,
  output logic EVT_READY,
  input wire logic CFG_WE,
  input wire logic [4:0] CFG_INDEX,
  input wire logic [pef_pkg::EVT_W-1:0] CFG_MATCH,
  input wire logic [pef_pkg::EVT_W-1:0] CFG_MASK,
  input wire logic [pef_pkg::NACT-1:0] CFG_ACTIONS,
  input wire logic [pef_pkg::DLY_W-1:0] CFG_DELAY,
  input wire logic CFG_ENABLE,
  input wire logic LOG_ENABLE,
  input wire logic FB_USE_BUS,
  input wire logic [3:0] FB_LEVEL,
  input wire logic HOST_POWER_OFF,
  output logic POWER_DOWN,
  output logic POWER_CYCLE,
  output logic SYS_RESET,
  output logic ACPI_PWR_BTN,
  output logic NMI,
  output logic ALERT,
  output logic [pef_pkg::EVT_W-1:0] ALERT_TARGET,
  output logic SENSOR_FB_REQ,
  output logic [3:0] DEVICE_FEEDBACK_IO_PINS,
  output logic MSG_EVENT,
  output logic FAULT_LED_BLINK,
  output logic ID_LED,
  output logic LOG_VALID,
  output logic [pef_pkg::NACT-1:0] LOG_ACTIONS,
  output logic LOG_EXTERNAL,
  output logic [pef_pkg::EVT_W-1:0] LOG_EVENT
);
  localparam int N = pef_pkg::ENTRIES;
  localparam int A = pef_pkg::NACT;

  logic [pef_pkg::EVT_W-1:0] f_match [N];
  logic [pef_pkg::EVT_W-1:0] f_mask [N];
  logic [A-1:0] f_act [N];
  logic [pef_pkg::DLY_W-1:0] f_dly [N];
  logic [N-1:0] f_en;
  logic [N-1:0] blink_req;
  logic [N-1:0] next_blink_req;

  // one-cycle compare of the whole table
  logic [A-1:0] hit_act;
  logic [pef_pkg::DLY_W-1:0] hit_dly;
  logic [N-1:0] hit;
  always_comb begin
    hit_act = '0;
    hit_dly = '0;
    next_blink_req = blink_req;
    for (int i = 0; i < N; i++) begin
      hit[i] = f_en[i] &&
        ((EVT_DATA & f_mask[i]) == (f_match[i] & f_mask[i]));
      if (hit[i]) begin
        hit_act = hit_act | f_act[i];
        if (f_act[i][pef_pkg::ACT_FLED]) begin
          next_blink_req[i] = EVT_ASSERT;
        end
        // shortest nonzero delay wins so a reduced delay takes over
        if (f_dly[i] != '0 &&
            (hit_dly == '0 || f_dly[i] < hit_dly)) begin
          hit_dly = f_dly[i];
        end
      end
    end
    if (!EVT_VALID) begin
      hit_act = '0;
      next_blink_req = blink_req;
    end
    if (hit_dly > pef_pkg::MAX_DELAY) begin
      hit_dly = pef_pkg::MAX_DELAY;
    end
  end

  // table writes; fixed default keeps all entries off
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      f_en <= '0;
      blink_req <= '0;
    end else begin
      blink_req <= next_blink_req;
      if (CFG_WE && CFG_INDEX < 5'(N)) begin
        f_en[CFG_INDEX] <= CFG_ENABLE;
      end
    end
  end
  always_ff @(posedge MCLK) begin
    if (CFG_WE && CFG_INDEX < 5'(N)) begin
      f_match[CFG_INDEX] <= CFG_MATCH;
      f_mask[CFG_INDEX] <= CFG_MASK;
      f_act[CFG_INDEX] <= CFG_ACTIONS;
      f_dly[CFG_INDEX] <= CFG_DELAY;
    end
  end

  // merge and resolve: power-down wins over its group
  logic [A-1:0] resolved;
  always_comb begin
    resolved = hit_act;
    if (hit_act[pef_pkg::ACT_PDOWN]) begin
      resolved = hit_act & ~pef_pkg::PDOWN_SUPPRESS;
    end
  end

  // deferred group: only one of pdown/soft/cycle/reset runs, highest rank
  logic [A-1:0] defer_pick;
  always_comb begin
    defer_pick = '0;
    for (int k = pef_pkg::ACT_RESET; k >= pef_pkg::ACT_PDOWN; k--) begin
      if (resolved[k]) begin
        defer_pick = '0;
        defer_pick[k] = 1'b1;
      end
    end
  end

  logic [A-1:0] pend;
  logic [A-1:0] next_pend;
  logic [pef_pkg::DLY_W-1:0] pend_dly;
  logic [pef_pkg::DLY_W-1:0] next_pend_dly;
  logic [31:0] unit_cnt;
  logic [31:0] next_unit_cnt;
  logic [A-1:0] fire;
  logic new_defer;
  logic take;
  assign new_defer = |(defer_pick & pef_pkg::DEFERRABLE);
  // a new request replaces the pending one if it is sooner, or equally soon and higher rank
  assign take = new_defer && (pend == '0 || hit_dly < pend_dly ||
    (hit_dly == pend_dly && defer_pick < pend));

  always_comb begin
    next_pend = pend;
    next_pend_dly = pend_dly;
    next_unit_cnt = unit_cnt;
    fire = resolved & ~pef_pkg::DEFERRABLE;
    if (take) begin
      next_pend = defer_pick;
      next_pend_dly = hit_dly;
      next_unit_cnt = 32'(UNIT_CYCLES - 1);
    end else if (pend != '0) begin
      if (pend_dly == '0) begin
        fire = fire | pend;
        next_pend = '0;
      end else if (unit_cnt == '0) begin
        next_pend_dly = pend_dly - 1'b1;
        next_unit_cnt = 32'(UNIT_CYCLES - 1);
      end else begin
        next_unit_cnt = unit_cnt - 1;
      end
    end
  end

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      pend <= '0;
      pend_dly <= '0;
      unit_cnt <= '0;
    end else begin
      pend <= next_pend;
      pend_dly <= next_pend_dly;
      unit_cnt <= next_unit_cnt;
    end
  end

  // nmi once until reset or power-down
  logic nmi_armed;
  logic next_nmi_armed;
  logic nmi_busy;
  logic btn_busy;
  logic nmi_go;
  assign nmi_go = fire[pef_pkg::ACT_DIAG] && nmi_armed;
  always_comb begin
    next_nmi_armed = nmi_armed;
    if (nmi_go) begin
      next_nmi_armed = 1'b0;
    end
    if (HOST_POWER_OFF || fire[pef_pkg::ACT_PDOWN]) begin
      next_nmi_armed = 1'b1;
    end
  end

  pef_timer #(.W(32)) u_nmi (
    .clk(MCLK),
    .rst(SYS_RST),
    .load(nmi_go),
    .value(32'(NMI_CYCLES)),
    .busy(nmi_busy),
    .expire()
  );
  pef_timer #(.W(32)) u_btn (
    .clk(MCLK),
    .rst(SYS_RST),
    .load(fire[pef_pkg::ACT_SOFT]),
    .value(32'(BTN_CYCLES)),
    .busy(btn_busy),
    .expire()
  );

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      nmi_armed <= 1'b1;
      POWER_DOWN <= 1'b0;
      POWER_CYCLE <= 1'b0;
      SYS_RESET <= 1'b0;
      ALERT <= 1'b0;
      SENSOR_FB_REQ <= 1'b0;
      DEVICE_FEEDBACK_IO_PINS <= 4'h0;
      MSG_EVENT <= 1'b0;
      ID_LED <= 1'b0;
      LOG_VALID <= 1'b0;
      LOG_ACTIONS <= '0;
      LOG_EXTERNAL <= 1'b0;
      LOG_EVENT <= '0;
    end else begin
      nmi_armed <= next_nmi_armed;
      POWER_DOWN <= fire[pef_pkg::ACT_PDOWN];
      POWER_CYCLE <= fire[pef_pkg::ACT_CYCLE];
      SYS_RESET <= fire[pef_pkg::ACT_RESET];
      ALERT <= fire[pef_pkg::ACT_ALERT];
      SENSOR_FB_REQ <= fire[pef_pkg::ACT_SENSFB] && FB_USE_BUS;
      if (fire[pef_pkg::ACT_SENSFB] && !FB_USE_BUS) begin
        DEVICE_FEEDBACK_IO_PINS <= FB_LEVEL;
      end
      MSG_EVENT <= fire[pef_pkg::ACT_MSG];
      if (fire[pef_pkg::ACT_IDLED]) begin
        ID_LED <= ~ID_LED;
      end
      // every accepted event is logged, actions when enabled
      LOG_VALID <= EVT_VALID || (LOG_ENABLE && fire != '0);
      LOG_ACTIONS <= LOG_ENABLE ? fire : '0;
      LOG_EXTERNAL <= EVT_VALID && EVT_EXTERNAL;
      LOG_EVENT <= EVT_VALID ? EVT_DATA : '0;
    end
  end

  assign EVT_READY = 1'b1;
  assign NMI = nmi_busy;
  assign ACPI_PWR_BTN = btn_busy;
  assign FAULT_LED_BLINK = |blink_req;
  assign ALERT_TARGET = pef_pkg::ALERT_DEST;

  property p_pdown_blocks;
    @(posedge MCLK) disable iff (SYS_RST)
    (EVT_VALID && hit_act[pef_pkg::ACT_PDOWN]) |->
      ##1 (!SYS_RESET && !$rose(NMI));
  endproperty
  a_pdown_blocks: assert property (p_pdown_blocks)
    else $error("reset or nmi with pdown");
  property p_immediate;
    @(posedge MCLK) disable iff (SYS_RST)
    (EVT_VALID && resolved[pef_pkg::ACT_MSG]) |-> ##1 MSG_EVENT;
  endproperty
  a_immediate: assert property (p_immediate) else $error("msg late");
  property p_alert_now;
    @(posedge MCLK) disable iff (SYS_RST)
    (EVT_VALID && resolved[pef_pkg::ACT_ALERT]) |-> ##1 ALERT;
  endproperty
  a_alert_now: assert property (p_alert_now)
    else $error("alert late");
  property p_idled;
    @(posedge MCLK) disable iff (SYS_RST)
    (EVT_VALID && resolved[pef_pkg::ACT_IDLED]) |->
      ##1 (ID_LED != $past(ID_LED));
  endproperty
  a_idled: assert property (p_idled)
    else $error("id led not toggled");
  property p_nmi_once;
    @(posedge MCLK) disable iff (SYS_RST)
    $fell(nmi_armed) |-> NMI;
  endproperty
  a_nmi_once: assert property (p_nmi_once)
    else $error("nmi missing");
  property p_nmi_rearm;
    @(posedge MCLK) disable iff (SYS_RST)
    $rose(NMI) |-> $past(nmi_armed);
  endproperty
  a_nmi_rearm: assert property (p_nmi_rearm)
    else $error("nmi repeated while disarmed");
  // blink may only stop on a de-assert event or a reset
  property p_blink;
    @(posedge MCLK) disable iff (SYS_RST)
    $fell(FAULT_LED_BLINK) |->
      ($past(EVT_VALID && !EVT_ASSERT) || $past(SYS_RST));
  endproperty
  a_blink: assert property (p_blink) else $error("blink stopped");
endmodule : pef_engine
`default_nettype wire

// file: verif/pef_platform_model.sv
// platform side model: counts control pulses and measures pulse widths
`default_nettype none
module pef_platform_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic pd,
  input wire logic pc,
  input wire logic sr,
  input wire logic btn,
  input wire logic nmi,
  output logic [15:0] n_pd,
  output logic [15:0] n_pc,
  output logic [15:0] n_sr,
  output logic [15:0] n_btn,
  output logic [15:0] n_nmi,
  output logic [15:0] w_btn,
  output logic [15:0] w_nmi
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] run_btn;
  logic [15:0] run_nmi;
  always_ff @(posedge clk) begin
    if (rst) begin
      {n_pd, n_pc, n_sr, n_btn, n_nmi} <= '0;
      {w_btn, w_nmi, run_btn, run_nmi} <= '0;
    end else begin
      n_pd <= n_pd + {15'h0000, pd};
      n_pc <= n_pc + {15'h0000, pc};
      n_sr <= n_sr + {15'h0000, sr};
      run_btn <= btn ? run_btn + 16'h0001 : 16'h0000;
      run_nmi <= nmi ? run_nmi + 16'h0001 : 16'h0000;
      // width latched as each pulse falls
      if (!btn && run_btn != 16'h0000) begin
        n_btn <= n_btn + 16'h0001;
        w_btn <= run_btn;
      end
      if (!nmi && run_nmi != 16'h0000) begin
        n_nmi <= n_nmi + 16'h0001;
        w_nmi <= run_nmi;
      end
    end
  end
endmodule : pef_platform_model
`default_nettype wire

// file: verif/tb_platform_event_filter_actions.sv
// testbench for the platform event filter engine
`default_nettype none
module tb_platform_event_filter_actions;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ev_v = 1'b0, ev_x = 1'b0, ev_a = 1'b0, cf_we = 1'b0, hpo = 1'b0;
  logic cf_e = 1'b1, log_en = 1'b1, fb_bus = 1'b0;
  logic [15:0] ev_d = 16'h0000, cf_m = 16'h0000, cf_k = 16'h0000;
  logic [4:0] cf_i = 5'h00;
  logic [9:0] cf_a = 10'h000;
  logic [7:0] cf_d = 8'h00;
  logic [3:0] fb_lvl = 4'hA;
  logic rdy, pd, pc, sr, btn, nmi, alr, sfb, msg, blink, idled, lv, lx;
  logic [15:0] alt, le;
  logic [3:0] dfp;
  logic [9:0] la;
  logic [15:0] n_pd, n_pc, n_sr, n_btn, n_nmi, w_btn, w_nmi;
  int n_mismatch = 0;
  int comparisons = 0;

  // short counts keep deferral and pulse checks within a few dozen cycles
  pef_engine #(.UNIT_CYCLES(4), .NMI_CYCLES(8), .BTN_CYCLES(16)) dut (
    .MCLK(clk), .SYS_RST(rst), .EVT_VALID(ev_v), .EVT_EXTERNAL(ev_x),
    .EVT_DATA(ev_d), .EVT_ASSERT(ev_a), .EVT_READY(rdy), .CFG_WE(cf_we),
    .CFG_INDEX(cf_i), .CFG_MATCH(cf_m), .CFG_MASK(cf_k), .CFG_ACTIONS(cf_a),
    .CFG_DELAY(cf_d), .CFG_ENABLE(cf_e), .LOG_ENABLE(log_en),
    .FB_USE_BUS(fb_bus), .FB_LEVEL(fb_lvl), .HOST_POWER_OFF(hpo),
    .POWER_DOWN(pd), .POWER_CYCLE(pc), .SYS_RESET(sr), .ACPI_PWR_BTN(btn),
    .NMI(nmi), .ALERT(alr), .ALERT_TARGET(alt), .SENSOR_FB_REQ(sfb),
    .DEVICE_FEEDBACK_IO_PINS(dfp), .MSG_EVENT(msg), .FAULT_LED_BLINK(blink),
    .ID_LED(idled), .LOG_VALID(lv), .LOG_ACTIONS(la), .LOG_EXTERNAL(lx),
    .LOG_EVENT(le));

  pef_platform_model model (.clk(clk), .rst(rst), .pd(pd), .pc(pc),
    .sr(sr), .btn(btn), .nmi(nmi), .n_pd(n_pd), .n_pc(n_pc), .n_sr(n_sr),
    .n_btn(n_btn), .n_nmi(n_nmi), .w_btn(w_btn), .w_nmi(w_nmi));

  initial begin
    forever #4 clk = ~clk;
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wt

  task automatic cfg(input logic [4:0] i, input logic [15:0] m, k,
      input logic [9:0] a, input logic [7:0] d);
    @(negedge clk);
    {cf_we, cf_i, cf_m, cf_k, cf_a, cf_d} = {1'b1, i, m, k, a, d};
    @(negedge clk);
    cf_we = 1'b0;
  endtask : cfg

  task automatic ev(input logic [15:0] d, input logic a, x);
    @(negedge clk);
    {ev_v, ev_d, ev_a, ev_x} = {1'b1, d, a, x};
    @(negedge clk);
    ev_v = 1'b0;
  endtask : ev

  task automatic s_immediate;
    cfg(5'h00, 16'h0010, 16'hFFFF, 10'h0E0, 8'h00);
    cfg(5'h1D, 16'h0010, 16'h00F0, 10'h200, 8'h00);
    // index past the table end must be ignored
    cfg(5'h1E, 16'h00A0, 16'hFFFF, 10'h200, 8'h00);
    ev(16'h0010, 1'b1, 1'b1);
    chk(msg, 1'b1);
    chk({alr, sfb}, 2'h2);
    chk(rdy, 1'b1);
    chk(alt, pef_pkg::ALERT_DEST);
    chk(lv, 1'b1);
    chk(la, 10'h2E0);
    chk({lx, 15'h0000}, 16'h8000);
    chk(le, 16'h0010);
    wt(1);
    chk({msg, alr, sfb, lv}, 4'h0);
    chk(idled, 1'b1);
    chk(dfp, 4'hA);
    ev(16'h00A0, 1'b1, 1'b0);
    wt(3);
    chk(idled, 1'b1);
    // bus mode leaves the pins alone; logging off still logs the event
    @(negedge clk);
    {fb_bus, fb_lvl, log_en} = {1'b1, 4'h5, 1'b0};
    ev(16'h0010, 1'b1, 1'b0);
    chk(sfb, 1'b1);
    chk(dfp, 4'hA);
    chk(la, 10'h000);
    chk({lv, lx}, 2'h2);
    @(negedge clk);
    log_en = 1'b1;
  endtask : s_immediate

  task automatic s_pdown;
    cfg(5'h01, 16'h0020, 16'hFFFF, 10'h01F, 8'h00);
    ev(16'h0020, 1'b1, 1'b0);
    wt(20);
    chk(n_pd, 16'h0001);
    chk(n_pc + n_sr + n_btn + n_nmi, 16'h0000);
  endtask : s_pdown

  task automatic s_cycle_reset;
    cfg(5'h02, 16'h0030, 16'hFFFF, 10'h00C, 8'h00);
    ev(16'h0030, 1'b1, 1'b0);
    wt(20);
    chk(n_pc, 16'h0001);
    chk(n_sr, 16'h0000);
  endtask : s_cycle_reset

  task automatic s_defer;
    cfg(5'h03, 16'h0040, 16'hFFFF, 10'h008, 8'h02);
    cfg(5'h04, 16'h0050, 16'hFFFF, 10'h008, 8'h05);
    ev(16'h0050, 1'b1, 1'b0);
    ev(16'h0040, 1'b1, 1'b0);
    wt(4);
    chk(n_sr, 16'h0000);
    wt(10);
    chk(n_sr, 16'h0001);
    wt(30);
    chk(n_sr, 16'h0001);
  endtask : s_defer

  task automatic s_diag;
    cfg(5'h05, 16'h0060, 16'hFFFF, 10'h010, 8'h00);
    cfg(5'h06, 16'h0070, 16'hFFFF, 10'h002, 8'h00);
    ev(16'h0060, 1'b1, 1'b0);
    wt(20);
    chk(n_nmi, 16'h0001);
    chk(w_nmi, 16'h0008);
    ev(16'h0060, 1'b1, 1'b0);
    wt(20);
    chk(n_nmi, 16'h0001);
    @(negedge clk);
    hpo = 1'b1;
    @(negedge clk);
    hpo = 1'b0;
    ev(16'h0060, 1'b1, 1'b0);
    wt(20);
    chk(n_nmi, 16'h0002);
    ev(16'h0070, 1'b1, 1'b0);
    wt(30);
    chk(n_btn, 16'h0001);
    chk(w_btn, 16'h0010);
  endtask : s_diag

  task automatic s_blink;
    cfg(5'h07, 16'h0080, 16'hFFFF, 10'h100, 8'h00);
    cfg(5'h08, 16'h0090, 16'hFFFF, 10'h100, 8'h00);
    ev(16'h0080, 1'b1, 1'b0);
    ev(16'h0090, 1'b1, 1'b0);
    wt(2);
    chk(blink, 1'b1);
    ev(16'h0080, 1'b0, 1'b0);
    wt(2);
    chk(blink, 1'b1);
    ev(16'h0090, 1'b0, 1'b0);
    wt(2);
    chk(blink, 1'b0);
  endtask : s_blink

  task automatic close_out;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : close_out

  initial begin
    repeat (3000) @(posedge clk);
    n_mismatch++;
    close_out();
  end

  initial begin
    repeat (8) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    s_immediate();
    s_pdown();
    s_cycle_reset();
    s_defer();
    s_diag();
    s_blink();
    close_out();
  end
endmodule : tb_platform_event_filter_actions
`default_nettype wire
